// ### testbench/kdi_i2c_host.sv
// Bus master model standing in for the host processor
`timescale 1ns/10ps
module kdi_i2c_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic gap();
    repeat (6) @(negedge clk);
  endtask
  // One clock pulse: data set while the clock is low, sampled late in the high phase
  task automatic bit_x(input logic b, output logic r);
    repeat (2) @(negedge clk);
    sda_pull <= !b;
    gap();
    scl <= 1'b1;
    gap();
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic byte_x(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(last, r);
    ack = !r;
  endtask
  // Start when stop is low, else stop; the clock is left low after a start and high after a stop
  task automatic edge_cond(input logic stop);
    repeat (2) @(negedge clk);
    sda_pull <= stop;
    gap();
    scl <= 1'b1;
    gap();
    sda_pull <= !stop;
    gap();
    if (!stop) begin
      scl <= 1'b0;
    end
  endtask
  task automatic wr_reg(input logic [6:0] adr, input logic [7:0] ptr, input logic [7:0] d,
    output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    edge_cond(1'b0);
    byte_x({adr, 1'b0}, 1'b1, q, a0);
    byte_x(ptr, 1'b1, q, a1);
    byte_x(d, 1'b1, q, a2);
    edge_cond(1'b1);
    ok = a0 && a1 && a2;
  endtask
  task automatic rd_reg(input logic [6:0] adr, input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    edge_cond(1'b0);
    byte_x({adr, 1'b0}, 1'b1, d, a);
    byte_x(ptr, 1'b1, d, a);
    edge_cond(1'b0);
    byte_x({adr, 1'b1}, 1'b1, d, a);
    byte_x(8'hFF, 1'b1, d, a);
    edge_cond(1'b1);
  endtask
endmodule

// ### testbench/kdi_props.sv
// Pin-level assertions for the key and display interface
`timescale 1ns/10ps
module kdi_props (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_oe,
  input wire logic [7:0] key_in,
  input wire logic low_supply,
  input wire logic key_irq,
  input wire kdi_pkg::kdi_byte_t disp_data,
  input wire logic disp_clk,
  input wire logic disp_line,
  input wire logic disp_frame,
  input wire logic disp_on,
  input wire logic disp_rst_n
);
  import kdi_pkg::*;
  logic [11:0] rst_low_r;
  logic [8:0] col_r;
  logic [7:0] quiet_r;
  logic rst_seen_r, frame_ok_r, clk_q, frame_q, scl_q;
  // ==========================================
  // Helper counters
  always_ff @(posedge ref_clk) begin
    rst_low_r <= disp_rst_n ? 12'h000 : rst_low_r + 12'h001;
  end
  always_ff @(posedge ref_clk) begin
    rst_seen_r <= srst || (rst_seen_r && !disp_rst_n);
  end
  always_ff @(posedge ref_clk) begin
    clk_q <= disp_clk;
    frame_q <= disp_frame;
    scl_q <= scl_i;
  end
  // Cycles since the bus clock last moved
  always_ff @(posedge ref_clk) begin
    quiet_r <= (srst || scl_i != scl_q) ? 8'h00 : quiet_r + {7'h00, quiet_r != 8'hFF};
  end
  always_ff @(posedge ref_clk) begin
    frame_ok_r <= !(srst || !disp_rst_n) && (frame_ok_r || (disp_frame && !frame_q));
  end
  // Display clock rises since the last frame start
  always_ff @(posedge ref_clk) begin
    if (disp_frame && !frame_q) begin
      col_r <= {8'h00, disp_clk && !clk_q};
    end else if (disp_clk && !clk_q) begin
      col_r <= col_r + 9'h001;
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  a_press_raises_irq: assert property ((key_in & ~$past(key_in)) != 8'h00 |-> ##[1:8] key_irq)
    else $error("key press did not raise the interrupt");
  a_held_key_quiet: assert property ($stable(key_in) [*8] |=> !$rose(key_irq))
    else $error("interrupt rose without a key change");
  a_clear_by_bus: assert property ($fell(key_irq) |-> quiet_r < 8'h20)
    else $error("interrupt dropped without bus traffic");
  a_dclk_high: assert property (disable iff (srst || !disp_rst_n) $rose(disp_clk) |-> disp_clk [*4] ##1 !disp_clk)
    else $error("display clock high phase wrong");
  a_dclk_low: assert property (disable iff (srst || !disp_rst_n) $fell(disp_clk) |-> !disp_clk [*4] ##1 disp_clk)
    else $error("display clock low phase wrong");
  a_data_at_low: assert property (disable iff (srst || !disp_rst_n) $changed(disp_data) |-> !disp_clk)
    else $error("display data moved while clock high");
  a_frame_on_line0: assert property (disp_frame |-> !disp_line)
    else $error("frame mark outside first line");
  a_scan_len: assert property ($rose(disp_frame) && frame_ok_r |-> col_r == 9'h190)
    else $error("scan length is not two lines of forty cells");
  a_rst_width: assert property ($rose(disp_rst_n) && !rst_seen_r |-> rst_low_r == 12'h0C8)
    else $error("display reset pulse width wrong");
  a_brown_off: assert property ($rose(low_supply) && disp_on |-> ##[1:8] !disp_on)
    else $error("low supply did not switch display off");
  a_sda_still: assert property (@(posedge link_clk) disable iff (srst) scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("data line moved while bus clock high");
endmodule

// ### testbench/tb.sv
// Self-checking bench for the key and display interface
`timescale 1ns/10ps
`include "kdi_defs.svh"
module tb;
  import kdi_pkg::*;
  localparam int SCAN = `KDI_GLYPH_COLS * `KDI_CELLS * 2 * `KDI_DCLK_HALF;
  logic ref_clk, link_clk, srst, maint_sw, lang_sw, low_supply, scl_line, sda_pull, ok;
  logic sda_o, sda_oe, key_irq, beeper, disp_clk, disp_line, disp_frame, disp_on, disp_rst_n;
  logic [7:0] key_in;
  logic [2:0] status_led;
  kdi_byte_t disp_data, rd;
  wire sda_line;
  int bad_count, total_checks, cyc, n;
  // Open-drain data line with pull-up
  assign sda_line = (sda_pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
  kdi_top kdi_top_inst (.ref_clk(ref_clk), .srst(srst), .link_clk(link_clk), .scl_i(scl_line),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .key_in(key_in), .maint_sw(maint_sw),
    .lang_sw(lang_sw), .low_supply(low_supply), .key_irq(key_irq), .status_led(status_led),
    .beeper(beeper), .disp_data(disp_data), .disp_clk(disp_clk), .disp_line(disp_line),
    .disp_frame(disp_frame), .disp_on(disp_on), .disp_rst_n(disp_rst_n));
  kdi_i2c_host kdi_i2c_host_inst (.clk(link_clk), .sda(sda_line), .scl(scl_line),
    .sda_pull(sda_pull));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = !ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = !link_clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wr(input kdi_byte_t p, input kdi_byte_t d);
    kdi_i2c_host_inst.wr_reg(`KDI_I2C_ADDR, p, d, ok);
    chk(ok, 1'b1);
    @(negedge ref_clk);
  endtask
  task automatic rdr(input kdi_byte_t p);
    kdi_i2c_host_inst.rd_reg(`KDI_I2C_ADDR, p, rd);
    @(negedge ref_clk);
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge ref_clk);
  endtask
  task automatic t_keys();
    key_in = 8'h05;
    idle(12);
    chk(key_irq, 1'b1);
    rdr(`KDI_REG_KEY);
    chk(rd, 8'h05);
    rdr(`KDI_REG_STAT);
    chk(rd & 8'h01, 8'h01);
    wr(`KDI_REG_CTRL, 8'h08);
    chk(key_irq, 1'b0);
    key_in = 8'h01;
    idle(100);
    chk(key_irq, 1'b0);
    key_in = 8'h05;
    idle(12);
    chk(key_irq, 1'b1);
    key_in = 8'h87;
    idle(20);
    rdr(`KDI_REG_KEY);
    chk({key_irq, rd}, 9'h187);
    wr(`KDI_REG_CTRL, 8'h08);
    key_in = 8'h00;
    idle(20);
    chk(key_irq, 1'b0);
  endtask
  task automatic t_led();
    for (int i = 0; i < 3; i++) begin
      wr(`KDI_REG_LED, 8'h01 << i);
      chk(status_led, 3'h1 << i);
    end
    kdi_i2c_host_inst.wr_reg(`KDI_I2C_ADDR ^ 7'h01, `KDI_REG_LED, 8'h07, ok);
    chk({ok, status_led}, 4'h4);
    wr(`KDI_REG_CTRL, 8'h01);
    chk(beeper, 1'b1);
    wr(`KDI_REG_CTRL, 8'h00);
    chk(beeper, 1'b0);
  endtask
  task automatic t_sw();
    maint_sw = 1'b1;
    idle(20);
    rdr(`KDI_REG_STAT);
    chk(rd & 8'h0E, 8'h0A);
    wr(`KDI_REG_CTRL, 8'h10);
    rdr(`KDI_REG_STAT);
    chk(rd & 8'h0E, 8'h02);
    maint_sw = 1'b0;
    lang_sw = 1'b1;
    idle(20);
    rdr(`KDI_REG_STAT);
    chk(rd & 8'h0E, 8'h0C);
    wr(`KDI_REG_CTRL, 8'h10);
  endtask
  task automatic t_disp();
    int f = 0;
    int l = 0;
    int c = 0;
    int d = 0;
    wr(`KDI_REG_CURS, 8'h4F);
    wr(`KDI_REG_CHAR, 8'h41);
    wr(`KDI_REG_CHAR, `KDI_CHAR_LF);
    wr(`KDI_REG_CHAR, `KDI_CHAR_CR);
    repeat (SCAN) begin
      @(negedge ref_clk);
      f += disp_frame;
      l += disp_line;
      c += disp_clk;
      d += (disp_data !== 8'h00) && disp_line;
    end
    chk(16'(d), 16'(`KDI_GLYPH_COLS * 2 * `KDI_DCLK_HALF));
    chk(16'(f), 16'(2 * `KDI_DCLK_HALF));
    chk(16'(l), 16'(SCAN / 2));
    chk(16'(c), 16'(SCAN / 2));
  endtask
  task automatic t_dctl();
    wr(`KDI_REG_CTRL, 8'h04);
    chk(disp_rst_n, 1'b0);
    idle(300);
    chk(disp_rst_n, 1'b1);
    wr(`KDI_REG_CTRL, 8'h02);
    chk(disp_on, 1'b0);
    wr(`KDI_REG_CTRL, 8'h00);
    chk(disp_on, 1'b1);
  endtask
  task automatic t_brown();
    low_supply = 1'b1;
    for (n = 0; n < 20 && disp_on !== 1'b0; n++) begin
      @(negedge ref_clk);
    end
    for (n = 0; n < 1000 && disp_on !== 1'b1; n++) begin
      @(negedge ref_clk);
    end
    chk(16'(n), 16'(`KDI_BROWN_OFF_CYC));
    low_supply = 1'b0;
  endtask
  initial begin
    srst = 1'b1;
    key_in = 8'h00;
    maint_sw = 1'b0;
    lang_sw = 1'b0;
    low_supply = 1'b0;
    idle(5);
    srst = 1'b0;
    idle(20);
    t_keys();
    t_led();
    t_sw();
    t_disp();
    t_dctl();
    t_brown();
    wrap_up();
  end
endmodule
bind kdi_top kdi_props kdi_props_inst (.ref_clk(ref_clk), .srst(srst), .link_clk(link_clk),
  .scl_i(scl_i), .sda_oe(sda_oe), .key_in(key_in), .low_supply(low_supply), .key_irq(key_irq),
  .disp_data(disp_data), .disp_clk(disp_clk), .disp_line(disp_line), .disp_frame(disp_frame),
  .disp_on(disp_on), .disp_rst_n(disp_rst_n));

// ### verilog/kdi_defs.svh
// Constants for the front panel key and display interface
`ifndef KDI_DEFS_SVH
`define KDI_DEFS_SVH
// ==========================================
// Bus address and register pointers
`define KDI_I2C_ADDR 7'h3A
`define KDI_REG_KEY 8'h00
`define KDI_REG_STAT 8'h01
`define KDI_REG_LED 8'h02
`define KDI_REG_CTRL 8'h03
`define KDI_REG_CHAR 8'h04
`define KDI_REG_CURS 8'h05
// ==========================================
// Field positions
`define KDI_STAT_FLAG 0
`define KDI_STAT_MAINT 1
`define KDI_STAT_LANG 2
`define KDI_STAT_SWCHG 3
`define KDI_CTRL_BEEP 0
`define KDI_CTRL_DOFF 1
`define KDI_CTRL_DRST 2
`define KDI_CTRL_KACK 3
`define KDI_CTRL_SACK 4
// ==========================================
// Reset values
`define KDI_LED_RST 3'h0
`define KDI_CTRL_RST 2'h0
`define KDI_CELL_RST 8'h20
// ==========================================
// Display geometry and timing
`define KDI_LINES 2
`define KDI_CHARS 40
`define KDI_CELLS 80
`define KDI_GLYPH_COLS 5
`define KDI_CHAR_CR 8'h0D
`define KDI_CHAR_LF 8'h0A
`define KDI_CLK_NS 5
`define KDI_DRST_NS 1000
`define KDI_DRST_CYC ((`KDI_DRST_NS + `KDI_CLK_NS - 1) / `KDI_CLK_NS)
`define KDI_BROWN_OFF_NS 2000
`define KDI_BROWN_OFF_CYC ((`KDI_BROWN_OFF_NS + `KDI_CLK_NS - 1) / `KDI_CLK_NS)
`define KDI_DCLK_HALF 4
`endif

// ### verilog/kdi_i2c_slave.sv
// Bus slave running on the link clock
`timescale 1ns/10ps
`include "kdi_defs.svh"
module kdi_i2c_slave (
  input wire logic link_clk,
  input wire logic srst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  kdi_link_if.slave lnk
);
  import kdi_pkg::*;

  // ==========================================
  // Reset and pin synchronisers
  logic lrst_a, lrst_b;
  logic [1:0] pin_a, pin_b, pin_c, pin_f, pin_p;
  logic req_a, req_b;
  always_ff @(posedge link_clk) begin
    lrst_a <= srst;
    lrst_b <= lrst_a;
    pin_a <= {scl_i, sda_i};
    pin_b <= pin_a;
    pin_c <= pin_b;
    req_a <= lnk.st_req;
    req_b <= req_a;
  end
  always_ff @(posedge link_clk) begin
    if (lrst_b) begin
      pin_f <= 2'h3;
      pin_p <= 2'h3;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (pin_b[i] == pin_c[i]) pin_f[i] <= pin_c[i];
      end
      pin_p <= pin_f;
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = pin_f[1] & ~pin_p[1];
  assign scl_fall = ~pin_f[1] & pin_p[1];
  assign start_c = pin_f[1] & pin_p[1] & pin_p[0] & ~pin_f[0];
  assign stop_c = pin_f[1] & pin_p[1] & ~pin_p[0] & pin_f[0];

  // ==========================================
  // Status snapshot from the core
  kdi_byte_t key_l, stat_l;
  always_ff @(posedge link_clk) begin
    if (lrst_b) begin
      lnk.st_ack <= 1'b0;
      key_l <= 8'h00;
      stat_l <= 8'h00;
    end else if (req_b != lnk.st_ack) begin
      key_l <= lnk.st_key;
      stat_l <= lnk.st_stat;
      lnk.st_ack <= req_b;
    end
  end

  function automatic kdi_byte_t reg_read(input kdi_byte_t p, input kdi_byte_t k,
                                         input kdi_byte_t s);
    if (p == `KDI_REG_KEY) reg_read = k;
    else if (p == `KDI_REG_STAT) reg_read = s;
    else reg_read = 8'h00;
  endfunction

  // ==========================================
  // Protocol engine
  kdi_i2c_st_t st_r, nxt_r;
  logic [3:0] bit_r;
  kdi_byte_t sh_r, ptr_r, tx_r;
  logic rd_ok_r;
  kdi_byte_t rd_byte;
  assign rd_byte = reg_read(ptr_r, key_l, stat_l);
  assign sda_o = 1'b0;
  always_ff @(posedge link_clk) begin
    if (lrst_b) begin
      st_r <= KDI_IDLE;
      nxt_r <= KDI_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      tx_r <= 8'h00;
      rd_ok_r <= 1'b0;
      sda_oe <= 1'b0;
      lnk.wr_tgl <= 1'b0;
      lnk.wr_ptr <= 8'h00;
      lnk.wr_data <= 8'h00;
    end else if (start_c) begin
      st_r <= KDI_ADDR;
      bit_r <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      st_r <= KDI_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (st_r)
        KDI_ADDR, KDI_PTR, KDI_WR: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], pin_f[0]};
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            bit_r <= 4'h0;
            if (st_r == KDI_ADDR && sh_r[7:1] != `KDI_I2C_ADDR) begin
              st_r <= KDI_IDLE;
            end else begin
              sda_oe <= 1'b1;
              st_r <= KDI_ACK;
              if (st_r == KDI_ADDR) begin
                nxt_r <= sh_r[0] ? KDI_RD : KDI_PTR;
              end else if (st_r == KDI_PTR) begin
                ptr_r <= sh_r;
                nxt_r <= KDI_WR;
              end else begin
                lnk.wr_ptr <= ptr_r;
                lnk.wr_data <= sh_r;
                lnk.wr_tgl <= ~lnk.wr_tgl;
                ptr_r <= ptr_r + 8'h01;
                nxt_r <= KDI_WR;
              end
            end
          end
        end
        KDI_ACK: begin
          if (scl_fall) begin
            st_r <= nxt_r;
            if (nxt_r == KDI_RD) begin
              tx_r <= rd_byte;
              sda_oe <= ~rd_byte[7];
            end else begin
              sda_oe <= 1'b0;
            end
          end
        end
        KDI_RD: begin
          if (scl_rise) begin
            bit_r <= bit_r + 4'h1;
          end else if (scl_fall) begin
            if (bit_r == 4'h8) begin
              sda_oe <= 1'b0;
              bit_r <= 4'h0;
              ptr_r <= ptr_r + 8'h01;
              st_r <= KDI_RACK;
            end else begin
              sda_oe <= ~tx_r[3'h7 - bit_r[2:0]];
            end
          end
        end
        KDI_RACK: begin
          if (scl_rise) begin
            rd_ok_r <= ~pin_f[0];
          end else if (scl_fall) begin
            if (rd_ok_r) begin
              st_r <= KDI_RD;
              tx_r <= rd_byte;
              sda_oe <= ~rd_byte[7];
            end else begin
              st_r <= KDI_IDLE;
            end
          end
        end
        default: st_r <= KDI_IDLE;
      endcase
    end
  end
endmodule

// ### verilog/kdi_link_if.sv
// Signals passed between the bus slave and the core
`timescale 1ns/10ps
interface kdi_link_if;
  logic wr_tgl;
  kdi_pkg::kdi_byte_t wr_ptr;
  kdi_pkg::kdi_byte_t wr_data;
  logic st_req;
  logic st_ack;
  kdi_pkg::kdi_byte_t st_key;
  kdi_pkg::kdi_byte_t st_stat;
  modport slave (
    output wr_tgl, output wr_ptr, output wr_data, output st_ack,
    input st_req, input st_key, input st_stat
  );
  modport core (
    input wr_tgl, input wr_ptr, input wr_data, input st_ack,
    output st_req, output st_key, output st_stat
  );
endinterface

// ### verilog/kdi_pkg.sv
// Types shared by the key and display interface modules
package kdi_pkg;
  typedef enum logic [2:0] {
    KDI_IDLE, KDI_ADDR, KDI_PTR, KDI_WR, KDI_ACK, KDI_RD, KDI_RACK
  } kdi_i2c_st_t;
  typedef logic [7:0] kdi_byte_t;
endpackage

// ### verilog/kdi_top.sv
// Front panel key, indicator and display interface core
// What this block does
// [R1] Any key line change captures all eight
// [R2] Capture with a newly pressed key sets the key-press flag
// [R3] Flag drives a dedicated interrupt status pin
// [R4] Host acknowledge clears flag and interrupt
// [R5] Held key yields one press event
// [R6] All other host traffic uses the bus
// [R7] Host masters the bus and addresses transfers
// [R8] Host commands set indicators and beeper
// [R9] Report optional switch opening or closing
// [R10] Convert host characters into bitmap image
// [R11] Image is two lines of forty characters
// [R12] Generate clock syncing converter and display
// [R13] Host command turns display off or resets
// [R14] Low supply cycles display off then on
// [R15] Flag holds while word tracks further changes
`timescale 1ns/10ps
`include "kdi_defs.svh"
module kdi_top (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [7:0] key_in,
  input wire logic maint_sw,
  input wire logic lang_sw,
  input wire logic low_supply,
  output logic key_irq,
  output logic [2:0] status_led,
  output logic beeper,
  output kdi_pkg::kdi_byte_t disp_data,
  output logic disp_clk,
  output logic disp_line,
  output logic disp_frame,
  output logic disp_on,
  output logic disp_rst_n
);
  import kdi_pkg::*;

  kdi_link_if lnk ();

  // Host access runs on the link clock [R6] [R7]
  kdi_i2c_slave u_slave (
    .link_clk(link_clk),
    .srst(srst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .lnk(lnk)
  );

  // ==========================================
  // Pin synchronisers: a change counts when stages two and three agree
  localparam int NPIN = 11;
  logic [NPIN-1:0] pin_raw, pin_a, pin_b, pin_c, pin_f;
  assign pin_raw = {low_supply, lang_sw, maint_sw, key_in};
  generate
    for (genvar g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        pin_a[g] <= pin_raw[g];
        pin_b[g] <= pin_a[g];
        pin_c[g] <= pin_b[g];
      end
      always_ff @(posedge ref_clk) begin
        if (srst) pin_f[g] <= 1'b0;
        else if (pin_b[g] == pin_c[g]) pin_f[g] <= pin_c[g];
      end
    end
  endgenerate

  // ==========================================
  // Write events from the link domain
  logic tgl_a, tgl_b, tgl_c, wr_ev;
  always_ff @(posedge ref_clk) begin
    tgl_a <= lnk.wr_tgl;
    tgl_b <= tgl_a;
    tgl_c <= tgl_b;
  end
  assign wr_ev = tgl_b ^ tgl_c;

  function automatic logic wr_hit(input logic ev, input kdi_byte_t p, input kdi_byte_t r);
    wr_hit = ev && (p == r);
  endfunction

  logic ctrl_wr, led_wr, char_wr, curs_wr;
  logic key_ack, sw_ack, drst_cmd;
  assign ctrl_wr = wr_hit(wr_ev, lnk.wr_ptr, `KDI_REG_CTRL);
  assign led_wr = wr_hit(wr_ev, lnk.wr_ptr, `KDI_REG_LED);
  assign char_wr = wr_hit(wr_ev, lnk.wr_ptr, `KDI_REG_CHAR);
  assign curs_wr = wr_hit(wr_ev, lnk.wr_ptr, `KDI_REG_CURS);
  assign key_ack = ctrl_wr & lnk.wr_data[`KDI_CTRL_KACK];
  assign sw_ack = ctrl_wr & lnk.wr_data[`KDI_CTRL_SACK];
  assign drst_cmd = ctrl_wr & lnk.wr_data[`KDI_CTRL_DRST];

  // ==========================================
  // Key capture and key-press flag
  logic [7:0] keys_s, keys_prev_r, key_word_r;
  logic key_flag_r, key_chg, key_new_press;
  assign keys_s = pin_f[7:0];
  assign key_chg = keys_s != keys_prev_r;
  assign key_new_press = |(keys_s & ~keys_prev_r);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      keys_prev_r <= 8'h00;
      key_word_r <= 8'h00;
    end else begin
      keys_prev_r <= keys_s;
      if (key_chg) key_word_r <= keys_s; // [R1] [R15]
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) key_flag_r <= 1'b0;
    else if (key_chg && key_new_press) key_flag_r <= 1'b1; // [R2] [R5] [R15]
    else if (key_ack) key_flag_r <= 1'b0; // [R4]
  end
  assign key_irq = key_flag_r; // [R3]

  // ==========================================
  // Optional switches
  logic [1:0] sw_prev_r;
  logic sw_chg_r;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sw_prev_r <= 2'h0;
      sw_chg_r <= 1'b0;
    end else begin
      sw_prev_r <= pin_f[9:8];
      if (pin_f[9:8] != sw_prev_r) sw_chg_r <= 1'b1; // [R9]
      else if (sw_ack) sw_chg_r <= 1'b0;
    end
  end

  // ==========================================
  // Status words toward the link domain
  logic ack_a, ack_b;
  kdi_byte_t stat_w;
  always_comb begin
    stat_w = 8'h00;
    stat_w[`KDI_STAT_FLAG] = key_flag_r;
    stat_w[`KDI_STAT_MAINT] = pin_f[8];
    stat_w[`KDI_STAT_LANG] = pin_f[9];
    stat_w[`KDI_STAT_SWCHG] = sw_chg_r;
  end
  always_ff @(posedge ref_clk) begin
    ack_a <= lnk.st_ack;
    ack_b <= ack_a;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lnk.st_req <= 1'b0;
      lnk.st_key <= 8'h00;
      lnk.st_stat <= 8'h00;
    end else if (ack_b == lnk.st_req) begin
      lnk.st_key <= key_word_r;
      lnk.st_stat <= stat_w; // [R9]
      lnk.st_req <= ~lnk.st_req;
    end
  end

  // ==========================================
  // Indicators, beeper and display control bits
  logic doff_r;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_led <= `KDI_LED_RST;
      {doff_r, beeper} <= `KDI_CTRL_RST;
    end else begin
      if (led_wr) status_led <= lnk.wr_data[2:0]; // [R8]
      if (ctrl_wr) begin
        beeper <= lnk.wr_data[`KDI_CTRL_BEEP]; // [R8]
        doff_r <= lnk.wr_data[`KDI_CTRL_DOFF]; // [R13]
      end
    end
  end

  // ==========================================
  // Display reset pulse and brown-out cycling
  localparam int DRST_W = $clog2(`KDI_DRST_CYC + 1);
  localparam int BRN_W = $clog2(`KDI_BROWN_OFF_CYC + 1);
  logic [DRST_W-1:0] drst_cnt_r;
  logic [BRN_W-1:0] brn_cnt_r;
  logic low_prev_r;
  always_ff @(posedge ref_clk) begin
    if (srst) drst_cnt_r <= '0;
    else if (drst_cmd) drst_cnt_r <= DRST_W'(`KDI_DRST_CYC); // [R13]
    else if (drst_cnt_r != '0) drst_cnt_r <= drst_cnt_r - 1'b1;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      low_prev_r <= 1'b0;
      brn_cnt_r <= '0;
    end else begin
      low_prev_r <= pin_f[10];
      if (pin_f[10] && !low_prev_r) brn_cnt_r <= BRN_W'(`KDI_BROWN_OFF_CYC); // [R14]
      else if (brn_cnt_r != '0) brn_cnt_r <= brn_cnt_r - 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      disp_on <= 1'b0;
      disp_rst_n <= 1'b0;
    end else begin
      disp_on <= !doff_r && (brn_cnt_r == '0); // [R13] [R14]
      disp_rst_n <= (drst_cnt_r == '0); // [R13]
    end
  end

  // ==========================================
  // Character memory written in teletype fashion
  kdi_byte_t cells [`KDI_CELLS];
  logic [6:0] cur_r;

  // Cells clear to blanks so an unwritten position shows nothing
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < `KDI_CELLS; i++) begin
        cells[i] <= `KDI_CELL_RST;
      end
    end else if (char_wr && lnk.wr_data != `KDI_CHAR_CR && lnk.wr_data != `KDI_CHAR_LF) begin
      cells[cur_r] <= lnk.wr_data; // [R10]
    end
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cur_r <= 7'h00;
    end else if (curs_wr) begin
      cur_r <= (lnk.wr_data < 8'(`KDI_CELLS)) ? lnk.wr_data[6:0] : 7'h00;
    end else if (char_wr) begin
      if (lnk.wr_data == `KDI_CHAR_CR) begin
        cur_r <= (cur_r < 7'(`KDI_CHARS)) ? 7'h00 : 7'(`KDI_CHARS);
      end else if (lnk.wr_data == `KDI_CHAR_LF) begin
        cur_r <= (cur_r < 7'(`KDI_CHARS)) ? cur_r + 7'(`KDI_CHARS)
                                          : cur_r - 7'(`KDI_CHARS); // [R11]
      end else begin
        cur_r <= (cur_r == 7'(`KDI_CELLS - 1)) ? 7'h00 : cur_r + 7'h01;
      end
    end
  end

  // Simple boxed glyphs; blank for space and control codes
  function automatic kdi_byte_t glyph_col(input kdi_byte_t c, input logic [2:0] col);
    if (c <= 8'h20) glyph_col = 8'h00;
    else if (col == 3'h0 || col == 3'(`KDI_GLYPH_COLS - 1)) glyph_col = 8'h7F;
    else glyph_col = {1'b0, 1'b1, c[5:0] >> col} | 8'h41;
  endfunction

  // ==========================================
  // Display clock and scan of the image
  logic [2:0] div_r, col_r;
  logic [5:0] chr_r;
  logic line_r;
  always_ff @(posedge ref_clk) begin
    if (srst || !disp_rst_n) begin
      div_r <= 3'h0;
      disp_clk <= 1'b0;
    end else if (div_r == 3'(`KDI_DCLK_HALF - 1)) begin
      div_r <= 3'h0;
      disp_clk <= ~disp_clk; // [R12]
    end else begin
      div_r <= div_r + 3'h1;
    end
  end
  logic dclk_fall;
  assign dclk_fall = disp_clk && div_r == 3'(`KDI_DCLK_HALF - 1);
  always_ff @(posedge ref_clk) begin
    if (srst || !disp_rst_n) begin
      col_r <= 3'h0;
      chr_r <= 6'h00;
      line_r <= 1'b0;
    end else if (dclk_fall) begin
      if (col_r != 3'(`KDI_GLYPH_COLS - 1)) begin
        col_r <= col_r + 3'h1;
      end else begin
        col_r <= 3'h0;
        if (chr_r != 6'(`KDI_CHARS - 1)) begin
          chr_r <= chr_r + 6'h01;
        end else begin
          chr_r <= 6'h00;
          line_r <= ~line_r; // [R11]
        end
      end
    end
  end
  logic [6:0] cell_idx;
  assign cell_idx = line_r ? 7'(chr_r) + 7'(`KDI_CHARS) : 7'(chr_r);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      disp_data <= 8'h00;
      disp_line <= 1'b0;
      disp_frame <= 1'b0;
    end else begin
      disp_data <= glyph_col(cells[cell_idx], col_r); // [R10]
      disp_line <= line_r;
      disp_frame <= !line_r && chr_r == 6'h00 && col_r == 3'h0;
    end
  end
endmodule
